// [rtl/seed_top.sv]
// Serial EEPROM device: frame decode, write protect, array and self-timed programming
`timescale 1ns/1ns
// Overview of operation
// - Frame is start one, two-bit opcode, eight address bits, then data.
// - Opcode 10 reads the addressed sixteen-bit word.
// - Opcode 00 with address top bits 11 enables programming.
// - Opcode 01 with address and sixteen data bits programs one word.
// - Opcode 00 with top bits 01 plus data fills every word.
// - Opcode 00 with top bits 00 disables programming.
// - Opcode 11 with address erases that word.
// - Opcode 00 with top bits 10 erases the whole array.
// - Whole-array erase leaves every bit at one.
// - Program data is the last sixteen bits shifted in.
// - Self-timed operation finishes within 10 ms, then ready.
// - Chip select falling after a program command starts programming.
// - Chip select high while pending shows busy low, ready high.
// - Programming ignored unless enabled; powers up disabled.
// - Read output starts with one zero bit before the data.
module seed_top
   import seed_pkg::*;
#(
   parameter int PROG_CYC = SEED_PROG_CYC
)
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Serial interface from host, sampled on i_clk
   input  wire logic i_cs,
   input  wire logic i_serial_clock_in,
   input  wire logic i_din,
   // Serial output
   output      logic o_dout,
   output      logic o_dout_oe,
   // Status
   output      logic o_busy,
   output      logic o_prog_enabled
);
   // ======================================================
   // State
   typedef struct packed {
      seed_state_t                st;
      logic                       sclk;
      logic                       cs;
      logic [4:0]                 cnt;
      logic [1:0]                 opc;
      logic [7:0]                 addr;
      logic [15:0]                sh;
      logic                       en;
      seed_op_t                   pend;
      logic                       busy;
      logic                       rdy;
      logic [SEED_TMR_W-1:0]      tmr;
      logic [7:0]                 fill_a;
      logic                       dout;
      logic                       oe;
   } seed_st_t;

   seed_st_t          q;
   seed_st_t          d;
   logic [15:0]       mem [SEED_DEPTH];
   seed_op_t          f_in;
   seed_op_t          f_out;
   logic              f_in_valid;
   logic              f_in_ready;
   logic              f_out_valid;
   logic              f_pop;
   logic              mem_we;
   logic [7:0]        mem_a;
   logic [15:0]       mem_wd;
   logic              rise;

   function automatic logic [15:0] seed_shift(input logic [15:0] v, input logic b);
      seed_shift = {v[14:0], b};
   endfunction

   // Word address with the newest serial bit appended
   function automatic logic [7:0] seed_addr_in(input logic [7:0] v, input logic b);
      seed_addr_in = {v[6:0], b};
   endfunction

   assign rise = i_serial_clock_in && !q.sclk;

   seed_fifo #(
      .WIDTH ($bits(seed_op_t)),
      .DEPTH (SEED_FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_in_valid  (f_in_valid),
      .i_in_data   (f_in),
      .o_in_ready  (f_in_ready),
      .o_out_valid (f_out_valid),
      .o_out_data  (f_out),
      .i_out_ready (f_pop)
   );

   // ======================================================
   // Next state
   always_comb
   begin
      d          = q;
      d.sclk     = i_serial_clock_in;
      d.cs       = i_cs;
      f_in_valid = 1'b0;
      f_in       = q.pend;
      f_pop      = 1'b0;
      mem_we     = 1'b0;
      mem_a      = q.addr;
      mem_wd     = q.sh;
      // Falling chip select hands a pending operation to the programmer
      if (q.cs && !i_cs)
      begin
         if (q.pend.kind != SEED_PK_NONE && f_in_ready)
         begin
            f_in_valid  = 1'b1;
            d.busy      = 1'b1;
            d.pend.kind = SEED_PK_NONE;
         end
      end
      // ======================================================
      // Frame decode
      if (!i_cs)
      begin
         d.st  = SEED_IDLE;
         d.oe  = 1'b0;
         d.cnt = SEED_CNT_ZERO;
      end
      else if (rise)
      begin
         unique case (q.st)
            SEED_IDLE:
            begin
               // Status output is reset by a start bit with chip select high while not busy
               if (i_din && !q.busy)
               begin
                  d.st   = SEED_OPC;
                  d.cnt  = SEED_CNT_ONE;
                  d.oe   = 1'b0;
                  d.rdy  = 1'b0;
               end
            end
            SEED_OPC:
            begin
               d.opc = {q.opc[0], i_din};
               d.cnt = q.cnt + 1'b1;
               if (q.cnt == SEED_CNT_ADDR0 - 5'h0_001)
               begin
                  d.st = SEED_ADDR;
               end
            end
            SEED_ADDR:
            begin
               d.addr = seed_addr_in(q.addr, i_din);
               d.cnt  = q.cnt + 1'b1;
               d.sh   = SEED_ZERO_W;
               if (q.cnt == SEED_ADDR_LAST)
               begin
                  d.cnt = SEED_CNT_ZERO;
                  unique case (q.opc)
                     SEED_OP_READ:
                     begin
                        d.st   = SEED_READ;
                        d.dout = 1'b0;
                        d.oe   = 1'b1;
                        mem_a  = seed_addr_in(q.addr, i_din);
                        d.sh   = mem[mem_a];
                     end
                     SEED_OP_WRITE:
                     begin
                        d.st = SEED_DATA;
                     end
                     SEED_OP_ERASE:
                     begin
                        d.st = SEED_DRAIN;
                        if (q.en)
                        begin
                           d.pend = '{SEED_PK_ERASE, seed_addr_in(q.addr, i_din), SEED_ERASED};
                        end
                     end
                     default:
                     begin
                        d.st = SEED_DRAIN;
                        unique case (q.addr[6:5])
                           SEED_SUB_EN:   d.en = 1'b1;
                           SEED_SUB_DIS:  d.en = 1'b0;
                           SEED_SUB_FILL: d.st = SEED_DATA;
                           default:
                           begin
                              if (q.en)
                              begin
                                 d.pend = '{SEED_PK_ERASE_ARRAY, SEED_ZERO_A, SEED_ERASED};
                              end
                           end
                        endcase
                     end
                  endcase
               end
            end
            SEED_DATA:
            begin
               // Extra or missing bits: the last sixteen taken count
               d.sh = seed_shift(q.sh, i_din);
               if (q.en)
               begin
                  d.pend.kind = (q.opc == SEED_OP_WRITE) ? SEED_PK_WRITE : SEED_PK_FILL;
                  d.pend.addr = q.addr;
                  d.pend.data = seed_shift(q.sh, i_din);
               end
            end
            SEED_READ:
            begin
               // Shift out one bit per rising edge, then roll to next address
               d.dout = q.sh[15];
               d.sh   = seed_shift(q.sh, 1'b0);
               d.cnt  = q.cnt + 1'b1;
               if (q.cnt == SEED_DATA_LAST)
               begin
                  d.cnt  = SEED_CNT_ZERO;
                  d.addr = q.addr + 1'b1;
                  mem_a  = q.addr + 1'b1;
                  d.sh   = mem[mem_a];
               end
            end
            default:
            begin
               d.st = SEED_DRAIN;
            end
         endcase
      end
      // Busy/ready shown once chip select is high again after a start
      // Ready stays on the pin until the next start bit clears it
      if (i_cs && (q.busy || d.rdy) && q.st == SEED_IDLE)
      begin
         d.oe   = 1'b1;
         d.dout = !q.busy;
      end
      // ======================================================
      // Self-timed programmer; fill and erase-all walk every word
      if (f_out_valid)
      begin
         d.tmr = q.tmr + 1'b1;
         mem_we = 1'b1;
         mem_a  = q.fill_a;
         mem_wd = f_out.data;
         if (f_out.kind == SEED_PK_WRITE || f_out.kind == SEED_PK_ERASE)
         begin
            mem_a = f_out.addr;
         end
         else
         begin
            d.fill_a = q.fill_a + 1'b1;
         end
         if (q.tmr == SEED_TMR_W'(PROG_CYC - 1))
         begin
            f_pop    = 1'b1;
            d.tmr    = '0;
            d.fill_a = SEED_ZERO_A;
            d.busy   = 1'b0;
            d.rdy    = 1'b1;
            if (i_cs && q.st == SEED_IDLE)
            begin
               d.dout = 1'b1;
            end
         end
      end
   end

   // ======================================================
   // Outputs, each one a register bit
   assign o_dout         = q.dout;
   assign o_dout_oe      = q.oe;
   assign o_busy         = q.busy;
   assign o_prog_enabled = q.en;

   // ======================================================
   // Registers
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         q      <= '0;
         q.st   <= SEED_IDLE;
      end
      else
      begin
         q <= d;
      end
   end

   // ======================================================
   // Array write port
   // A fill writes one word per timer cycle, so PROG_CYC must cover the depth
   always_ff @(posedge i_clk)
   begin
      if (mem_we)
      begin
         mem[mem_a] <= mem_wd;
      end
   end
endmodule

// [rtl/seed_pkg.sv]
// Package for the serial EEPROM instruction decoder: constants, enums, structs
package seed_pkg;
   // ======================================================
   // Array geometry and frame layout
   localparam int         SEED_WORD_W    = 16;
   localparam int         SEED_ADDR_W    = 8;
   localparam int         SEED_DEPTH     = 256;
   localparam logic [4:0] SEED_ADDR_LAST = 5'h0_00A;
   localparam logic [4:0] SEED_DATA_LAST = 5'h0_00F;
   localparam logic [4:0] SEED_CNT_ZERO  = 5'h0_000;
   localparam logic [4:0] SEED_CNT_ONE   = 5'h0_001;
   localparam logic [4:0] SEED_CNT_ADDR0 = 5'h0_003;
   localparam logic [15:0] SEED_ERASED   = 16'hFFFF;
   localparam logic [15:0] SEED_ZERO_W   = 16'h0000;
   localparam logic [7:0] SEED_ZERO_A    = 8'h00;
   // ======================================================
   // Opcodes and extended sub-codes (top two address bits)
   localparam logic [1:0] SEED_OP_EXT    = 2'h0;
   localparam logic [1:0] SEED_OP_WRITE  = 2'h1;
   localparam logic [1:0] SEED_OP_READ   = 2'h2;
   localparam logic [1:0] SEED_OP_ERASE  = 2'h3;
   localparam logic [1:0] SEED_SUB_DIS   = 2'h0;
   localparam logic [1:0] SEED_SUB_FILL  = 2'h1;
   localparam logic [1:0] SEED_SUB_ERASE_ARRAY = 2'h2;
   localparam logic [1:0] SEED_SUB_EN    = 2'h3;
   // ======================================================
   // Programming time
   localparam int  SEED_CLK_MHZ     = 25;
   localparam int  SEED_PROG_MS     = 10;
   localparam int  SEED_PROG_CYC    = SEED_PROG_MS * 1000 * SEED_CLK_MHZ;
   localparam int  SEED_TMR_W       = 24;
   localparam int  SEED_FIFO_DEPTH  = 32;

   typedef enum logic [2:0] {
      SEED_IDLE  = 3'b000,
      SEED_OPC   = 3'b001,
      SEED_ADDR  = 3'b010,
      SEED_DATA  = 3'b011,
      SEED_READ  = 3'b100,
      SEED_DRAIN = 3'b101
   } seed_state_t;

   typedef enum logic [2:0] {
      SEED_PK_NONE  = 3'b000,
      SEED_PK_WRITE = 3'b001,
      SEED_PK_FILL  = 3'b010,
      SEED_PK_ERASE = 3'b011,
      SEED_PK_ERASE_ARRAY = 3'b100
   } seed_pend_t;

   // Serial pins into the device
   typedef struct packed {
      logic cs;
      logic sclk_rise;
      logic din;
   } seed_pins_t;

   // One array operation queued toward the self-timed programmer
   typedef struct packed {
      seed_pend_t        kind;
      logic [7:0]        addr;
      logic [15:0]       data;
   } seed_op_t;
endpackage

// [rtl/seed_fifo.sv]
// Parameterised valid/ready FIFO for queued array operations
`timescale 1ns/1ns
module seed_fifo
   import seed_pkg::*;
#(
   parameter int WIDTH = 27,
   parameter int DEPTH = 32
)
(
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output      logic             o_in_ready,
   // Drain side
   output      logic             o_out_valid,
   output      logic [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } seed_fifo_st_t;

   seed_fifo_st_t    st_q;
   seed_fifo_st_t    st_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   assign o_in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
   assign o_out_valid = (st_q.cnt != '0);
   assign o_out_data  = mem[st_q.rd];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_comb
   begin
      st_d = st_q;
      if (push)
      begin
         st_d.wr = st_q.wr + 1'b1;
      end
      if (pop)
      begin
         st_d.rd = st_q.rd + 1'b1;
      end
      st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Storage has no reset; only pointers and count need a defined value
   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[st_q.wr] <= i_in_data;
      end
   end
endmodule

// [verification/seed_top_props.sv]
// Concurrent checks on the serial EEPROM device ports
`timescale 1ns/1ns
module seed_top_props
   import seed_pkg::*;
#(
   parameter int PROG_CYC = SEED_PROG_CYC
)
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Serial pins
   input  wire logic i_cs,
   input  wire logic i_serial_clock_in,
   input  wire logic i_din,
   input  wire logic o_dout,
   input  wire logic o_dout_oe,
   // Status
   input  wire logic o_busy,
   input  wire logic o_prog_enabled
);
   // ======================================================
   // Busy length counter; margin covers queue and output latency
   localparam int BUSY_MAX = PROG_CYC + 64;
   logic [23:0] busy_cnt_q;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         busy_cnt_q <= 24'h00_0000;
      else
         busy_cnt_q <= o_busy ? busy_cnt_q + 24'h00_0001 : 24'h00_0000;
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   oe_cs_drop_a: assert property (!i_cs ##1 !i_cs |=> !o_dout_oe)
      else $error("dout enable held after chip select low");
   oe_needs_cs_a: assert property (o_dout_oe |-> $past(i_cs) || $past(i_cs, 2))
      else $error("dout enabled without chip select");
   busy_low_a: assert property (i_cs && o_busy && o_dout_oe |-> !o_dout)
      else $error("ready shown while busy");
   busy_at_fall_a: assert property ($rose(o_busy) |-> !$past(i_cs))
      else $error("busy began without chip select low");
   busy_time_a: assert property (busy_cnt_q <= BUSY_MAX)
      else $error("programming took too long");
   busy_needs_en_a: assert property ($rose(o_busy) |-> o_prog_enabled)
      else $error("programming started while disabled");
   ready_shown_a: assert property ($fell(o_busy) && i_cs |-> ##[0:2] (o_dout && o_dout_oe))
      else $error("ready not shown after programming");
   dis_idle_a: assert property ($fell(o_prog_enabled) |-> !o_busy)
      else $error("disabled while busy");
endmodule

bind seed_top seed_top_props #(.PROG_CYC(PROG_CYC)) props_u (
   .i_clk(i_clk), .i_rst(i_rst), .i_cs(i_cs), .i_serial_clock_in(i_serial_clock_in),
   .i_din(i_din), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_busy(o_busy),
   .o_prog_enabled(o_prog_enabled));

// [verification/seed_host.sv]
// Host controller model for the three-wire command interface
`timescale 1ns/1ns
module seed_host
(
   // Clock
   input  wire logic i_clk,
   // Serial pins
   input  wire logic i_dout,
   output      logic o_cs,
   output      logic o_sclk,
   output      logic o_din
);
   // ======================================================
   // Serial clock stands low outside frames
   initial
   begin
      o_cs = 1'b0;
      o_sclk = 1'b0;
      o_din = 1'b0;
   end

   // Shifts n bits MSB first; rd keeps the last 17 dout samples
   task automatic frame(input logic [31:0] bits, input int n, output logic [16:0] rd);
      rd = 17'h0_0000;
      o_cs <= 1'b1;
      for (int i = n - 1; i >= 0; i--)
      begin
         o_din <= bits[i];
         repeat (3) @(posedge i_clk);
         o_sclk <= 1'b1;
         repeat (3) @(posedge i_clk);
         rd = {rd[15:0], i_dout};
         o_sclk <= 1'b0;
      end
      // Idle data line toggles so a stale value is never mistaken for a bit
      o_din <= ~bits[0];
   endtask

   task automatic stop();
      repeat (2) @(posedge i_clk);
      o_cs <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask

   // Polls status for up to lim cycles; returns on ready or when lim runs out
   task automatic wait_ready(input int lim, output logic low0, output logic ok);
      o_cs <= 1'b1;
      repeat (4) @(posedge i_clk);
      low0 = (i_dout === 1'b0);
      ok = 1'b0;
      for (int i = 0; i < lim && !ok; i++)
      begin
         @(posedge i_clk);
         ok = (i_dout === 1'b1);
      end
      o_cs <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask
endmodule

// [verification/tb_seed_top.sv]
// Self-checking bench for the serial EEPROM device
`timescale 1ns/1ns
module tb_seed_top;
   import seed_pkg::*;
   // ======================================================
   // Short programming time keeps the run small
   localparam int PCYC = 300;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        cs;
   logic        sclk;
   logic        din;
   logic        dout;
   logic        oe;
   logic        busy;
   logic        en;
   logic [16:0] rd;
   logic        lo;
   logic        ok;
   logic [7:0]  a;
   logic [15:0] w;
   logic [31:0] fr;
   logic        dout_line;
   int          n_fail = 0;
   int          num_checks = 0;
   int          cyc = 0;

   always #20 i_clk = ~i_clk;

   // A released pin reads back as the inverse of its last value
   assign dout_line = oe ? dout : ~dout;

   seed_top #(.PROG_CYC(PCYC)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_cs(cs), .i_serial_clock_in(sclk),
      .i_din(din), .o_dout(dout), .o_dout_oe(oe), .o_busy(busy), .o_prog_enabled(en));
   seed_host host_u (.i_clk(i_clk), .i_dout(dout_line), .o_cs(cs), .o_sclk(sclk), .o_din(din));

   task automatic report_and_stop();
      $display("Checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic run(input logic [31:0] bits, input int n, input logic prog);
      host_u.frame(bits, n, rd);
      host_u.stop();
      chk("busy", 17'(prog), 17'(busy));
      if (prog)
      begin
         host_u.wait_ready(PCYC + 64, lo, ok);
         chk("busy_low", 17'(1'b1), 17'(lo));
         chk("ready", 17'(1'b1), 17'(ok));
      end
   endtask

   // Leading zeros ahead of the start bit come from the frame length
   task automatic rdw(input logic [7:0] ad, input int lz, input logic [15:0] exp);
      run({1'b1, SEED_OP_READ, ad, 16'h0000}, 27 + lz, 1'b0);
      chk("read", {1'b0, exp}, rd);
   endtask

   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         report_and_stop();
      end
   end

   initial
   begin
      void'($urandom(32633));
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      chk("en", 17'(1'b0), 17'(en));
      run({1'b1, SEED_OP_WRITE, 8'h05, 16'h1234}, 27, 1'b0);
      run({1'b1, SEED_OP_EXT, SEED_SUB_EN, 6'($urandom)}, 11, 1'b0);
      chk("en", 17'(1'b1), 17'(en));
      run({1'b1, SEED_OP_EXT, SEED_SUB_ERASE_ARRAY, 6'($urandom)}, 11, 1'b1);
      for (int i = 0; i < 4; i++)
         rdw((i == 0) ? 8'h05 : 8'($urandom), i, SEED_ERASED);
      for (int i = 0; i < 4; i++)
      begin
         a = (i == 0) ? 8'hFF : 8'($urandom);
         w = (i == 0) ? 16'h0000 : 16'($urandom);
         // Odd passes send three extra data bits ahead of the word
         fr = 32'({1'b1, SEED_OP_WRITE, a, w});
         if (i % 2)
            fr = 32'({1'b1, SEED_OP_WRITE, a, 3'($urandom), w});
         run(fr, 27 + 3 * (i % 2), 1'b1);
         rdw(a, 0, w);
      end
      run({1'b1, SEED_OP_ERASE, a}, 11, 1'b1);
      rdw(a, 0, SEED_ERASED);
      // Chip select raised only after the erase ends must still show ready
      host_u.frame({1'b1, SEED_OP_ERASE, a}, 11, rd);
      host_u.stop();
      repeat (PCYC + 20) @(posedge i_clk);
      host_u.wait_ready(1, lo, ok);
      chk("late_ready", 17'h0_0001, 17'({lo, ok}));
      w = 16'($urandom);
      run({1'b1, SEED_OP_EXT, SEED_SUB_FILL, 6'($urandom), w}, 27, 1'b1);
      rdw(8'h00, 0, w);
      rdw(8'($urandom), 1, w);
      run({1'b1, SEED_OP_EXT, SEED_SUB_DIS, 6'($urandom)}, 11, 1'b0);
      chk("en", 17'(1'b0), 17'(en));
      run({1'b1, SEED_OP_WRITE, a, ~w}, 27, 1'b0);
      rdw(a, 0, w);
      report_and_stop();
   end
endmodule
